/* verilog/swfs_pkg.sv */
package swfs_pkg;
    // word layout of the serial frame
    localparam int WORD_W = 16;
    localparam int NUM_OUT = 12;
    localparam int NUM_HS = 4;
    localparam int NUM_LS = 8;
    localparam int WD_POS = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 12;
    // register addresses carried in the word
    localparam logic [2:0] ADDR_OUT_CTRL = 3'h0;
    localparam logic [2:0] ADDR_DIRECT_EN = 3'h4;
    localparam logic [2:0] ADDR_LOGIC_FN = 3'h2;
    localparam logic [2:0] ADDR_OPEN_LOAD = 3'h1;
    localparam logic [2:0] ADDR_OVERCUR = 3'h5;
    // values after reset
    localparam logic [11:0] CFG_RST = 12'h000;
    localparam logic [15:0] WORD_RST = 16'h0000;
    // timing, clock at 125 MHz
    localparam int CLK_MHZ = 125;
    localparam int FILTER_TIME_NS = 10000;
    localparam int PEAK_TIME_US = 1000;
    localparam int FILTER_CYC = (FILTER_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int PEAK_CYC = PEAK_TIME_US * CLK_MHZ;
endpackage

/* verilog/swfs_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module swfs_sync #(
    parameter int W = 1
) (
    input wire logic clock, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous levels
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // two flops; the first one feeds only the second
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule
`default_nettype wire

/* verilog/swfs_buf.sv */
`timescale 1ns/10ps
`default_nettype none
module swfs_buf #(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    input wire logic clock, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    input wire logic [W-1:0] in_data, // word in
    output logic out_valid, // word waiting
    input wire logic out_ready, // drain takes word
    output logic [W-1:0] out_data // oldest word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    // honest flags straight from the fill count
    assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ff];

    // storage has no reset, only pointers and fill count do
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end

    // pointer wrap at the chosen depth
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* verilog/swfs_core.sv */
// Summary of operation
// - overtemperature and open load per output; overvoltage global; overcurrent low side
// - faults latch a one in status; cleared at chip-select rise once gone
// - low-side filter qualifies overcurrent when on, open load when off
// - fault flag low on any fault; live for overvoltage, high-side faults
// - low-side faults latch fault flag until command toggles or reset
// - overtemperature checked only while on; shuts only that output
// - overheated low side stays off until commanded off after cooling
// - overheated high side restarts by itself after cooling
// - overvoltage forces all outputs off and sets all twelve status bits
// - open load checked while off; high side enabled by 0, low by 1
// - high-side open load clearable when gone or output commanded on
// - reset enables high-side open load detection, disables low side
// - low-side overcurrent bit picks shutdown-and-report or plain limiting
// - shutdown mode: overcurrent past filter switches off and latches
// - overcurrent shutdown retried only by commanding off then on
// - limit mode: output stays on, no overcurrent report
// - limit bit 0: peak limit from switch-on until peak timer ends
// - limit bit 1: sustain limit only, no peak interval
// - 16-bit words msb first; input on falling, output on rising
// - chip select high: clock and input ignored, output released
// - output control word: 1 turns on, 0 turns off
// - readout: 1 per faulted output, three direct-input echo bits
// - status loaded at chip-select fall; word applied at its rise
// - frames not a multiple of 16 bits are discarded
// - bit 15 watchdog, bits 14..12 address, 11..0 per-output data
`timescale 1ns/10ps
`default_nettype none
module swfs_core #(
    parameter int CNT_W = 17,
    parameter int FILTER_CYC = swfs_pkg::FILTER_CYC,
    parameter int PEAK_CYC = swfs_pkg::PEAK_CYC
) (
    input wire logic clock, // 125 MHz system clock
    input wire logic rstn, // async reset, active low
    input wire logic cs_n, // serial chip select
    input wire logic sclk, // serial clock from host
    input wire logic si, // serial data in
    output logic so, // serial data out
    output logic so_oe_n, // low while so is driven
    input wire logic [3:0] highside_direct_in, // direct high-side inputs
    input wire logic lowside_direct_in, // shared low-side input
    input wire logic ov_sense, // supply overvoltage
    input wire logic [11:0] ot_sense, // overtemperature per output
    input wire logic [11:0] ol_sense, // open load per output
    input wire logic [7:0] oc_sense, // low-side drain over threshold
    output logic [3:0] high_side_outputs, // high-side gate drive
    output logic [7:0] low_side_outputs, // low-side gate drive
    output logic [3:0] hs_peak_limit, // 1: peak limit, 0: sustain
    output logic fault_flag_n // fault flag, active low
);
    localparam int NS = 41;
    logic [NS-1:0] raw;
    logic [NS-1:0] syn;
    logic cs_q, cs_sel_q, sclk_q, si_q, ls_in, ov;
    logic [3:0] hs_in;
    logic [11:0] ot, ol;
    logic [7:0] oc;

    // every pin passes two flops before use; chip select goes in inverted
    // so the zero reset of the flops reads as deselected, no false edge
    assign raw = {~cs_n, sclk, si, highside_direct_in, lowside_direct_in,
                  ov_sense, ot_sense, ol_sense, oc_sense};
    swfs_sync #(.W(NS)) u_sync (
        .clock(clock),
        .rstn(rstn),
        .d(raw),
        .q(syn)
    );
    assign {cs_sel_q, sclk_q, si_q, hs_in, ls_in, ov, ot, ol, oc} = syn;
    assign cs_q = ~cs_sel_q;

    // serial front end state
    logic cs_d_ff, sclk_d_ff;
    logic [15:0] sh_ff;
    logic [3:0] bit_cnt_ff;
    logic got_bit_ff;
    logic so_ff, so_oe_n_ff;
    logic cs_fall, cs_rise, sclk_fall, sclk_rise;
    logic frame_ok;

    // serial clock edges seen only while selected
    assign cs_fall = cs_d_ff & ~cs_q;
    assign cs_rise = ~cs_d_ff & cs_q;
    assign sclk_fall = ~cs_q & sclk_d_ff & ~sclk_q;
    assign sclk_rise = ~cs_q & ~sclk_d_ff & sclk_q;
    assign frame_ok = cs_rise & got_bit_ff & (bit_cnt_ff == 4'h0);

    // delayed copies for edge finding
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cs_d_ff <= 1'b1;
            sclk_d_ff <= 1'b0;
        end else begin
            cs_d_ff <= cs_q;
            sclk_d_ff <= sclk_q;
        end
    end

    // configuration registers and command state
    logic [11:0] socr_ff, dicr_ff, lfcr_ff, olcfg_ff, occfg_ff;
    logic wd_ff;
    logic [11:0] status_ff;
    logic [2:0] echo;

    // echo group picked by the last watchdog bit
    assign echo = wd_ff ? {hs_in[3], hs_in[2], ls_in} :
                          {ls_in, hs_in[1], hs_in[0]};

    // one shift register serves both directions, so daisy chains work
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sh_ff <= swfs_pkg::WORD_RST;
            bit_cnt_ff <= 4'h0;
            got_bit_ff <= 1'b0;
        end else if (cs_fall) begin
            sh_ff <= {wd_ff, echo, status_ff};
            bit_cnt_ff <= 4'h0;
            got_bit_ff <= 1'b0;
        end else if (sclk_fall) begin
            sh_ff <= {sh_ff[14:0], si_q};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            got_bit_ff <= 1'b1;
        end
    end

    // output bit loads at chip-select fall, then moves on rising edges; held low while deselected
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            so_ff <= 1'b0;
            so_oe_n_ff <= 1'b1;
        end else begin
            so_oe_n_ff <= cs_q;
            if (cs_fall) begin
                so_ff <= wd_ff;
            end else if (sclk_rise) begin
                so_ff <= sh_ff[15];
            end else if (cs_q) begin
                so_ff <= 1'b0;
            end
        end
    end
    assign so = so_ff;
    assign so_oe_n = so_oe_n_ff;

    // received words wait here until chip select is idle
    logic buf_in_ready, buf_out_valid, buf_pop;
    logic [15:0] word;
    assign buf_pop = buf_out_valid & cs_q;
    swfs_buf #(.W(swfs_pkg::WORD_W), .DEPTH(2)) u_buf (
        .clock(clock),
        .rstn(rstn),
        .in_valid(frame_ok),
        .in_ready(buf_in_ready),
        .in_data(sh_ff),
        .out_valid(buf_out_valid),
        .out_ready(buf_pop),
        .out_data(word)
    );

    // word is decoded by address on the way out of the buffer
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            socr_ff <= swfs_pkg::CFG_RST;
            dicr_ff <= swfs_pkg::CFG_RST;
            lfcr_ff <= swfs_pkg::CFG_RST;
            olcfg_ff <= swfs_pkg::CFG_RST;
            occfg_ff <= swfs_pkg::CFG_RST;
            wd_ff <= 1'b0;
        end else if (buf_pop) begin
            wd_ff <= word[swfs_pkg::WD_POS];
            unique case (word[swfs_pkg::ADDR_MSB:swfs_pkg::ADDR_LSB])
                swfs_pkg::ADDR_OUT_CTRL: socr_ff <= word[11:0];
                swfs_pkg::ADDR_DIRECT_EN: dicr_ff <= word[11:0];
                swfs_pkg::ADDR_LOGIC_FN: lfcr_ff <= word[11:0];
                swfs_pkg::ADDR_OPEN_LOAD: olcfg_ff <= word[11:0];
                swfs_pkg::ADDR_OVERCUR: occfg_ff <= word[11:0];
                default: ;
            endcase
        end
    end

    // commanded state: serial bit alone, or and/or with direct pin
    logic [11:0] din, cmd;
    assign din = {{8{ls_in}}, hs_in};
    assign cmd = (dicr_ff & socr_ff)
               | (~dicr_ff & lfcr_ff & socr_ff & din)
               | (~dicr_ff & ~lfcr_ff & (socr_ff | din));

    // output and protection state
    logic [11:0] drive_ff, ot_hold_ff, cmd_prev_ff;
    logic [7:0] oc_lock_ff, ls_flag_ff;
    logic [11:0] nxt_drive, ol_en, ot_ev, ol_ev, live, set_ev;
    logic [7:0] oc_arm, ol_arm, oc_fire, ol_fire, ls_toggle;
    logic [3:0] hs_live;

    // overvoltage and locks override the command
    assign nxt_drive = cmd & ~{12{ov}} & ~ot_hold_ff
                     & ~{oc_lock_ff, 4'h0};
    assign ol_en = {olcfg_ff[11:4], ~olcfg_ff[3:0]} & ~drive_ff;
    assign ot_ev = ot & drive_ff;
    assign oc_arm = oc & drive_ff[11:4] & occfg_ff[11:4];
    assign ol_arm = ol[11:4] & ol_en[11:4];
    assign ls_toggle = cmd[11:4] ^ cmd_prev_ff[11:4];

    // drive and thermal hold
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            drive_ff <= 12'h000;
            ot_hold_ff <= 12'h000;
            cmd_prev_ff <= 12'h000;
        end else begin
            drive_ff <= nxt_drive;
            cmd_prev_ff <= cmd;
            // high side: release when cool, so it restarts itself
            ot_hold_ff[3:0] <= ot_ev[3:0]
                             | (ot_hold_ff[3:0] & ot[3:0]);
            // low side: release needs cool and an off command
            ot_hold_ff[11:4] <= ot_ev[11:4]
                              | (ot_hold_ff[11:4]
                                 & (ot[11:4] | cmd[11:4]));
        end
    end

    // overcurrent lock, cleared only by an off command
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            oc_lock_ff <= 8'h00;
        end else begin
            oc_lock_ff <= oc_fire | (oc_lock_ff & cmd[11:4]);
        end
    end

    // per low-side filter; restarts whenever the drive changes
    logic [CNT_W-1:0] filt_ff [swfs_pkg::NUM_LS];
    for (genvar g = 0; g < swfs_pkg::NUM_LS; g++) begin : g_filt
        logic qual;
        logic hit;
        assign qual = (oc_arm[g] | ol_arm[g])
                    & ~(drive_ff[g+4] ^ nxt_drive[g+4]);
        assign hit = qual & (filt_ff[g] == CNT_W'(FILTER_CYC - 1));
        assign oc_fire[g] = hit & oc_arm[g];
        assign ol_fire[g] = hit & ol_arm[g];
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                filt_ff[g] <= '0;
            end else if (!qual) begin
                filt_ff[g] <= '0;
            end else if (filt_ff[g] != CNT_W'(FILTER_CYC)) begin
                filt_ff[g] <= filt_ff[g] + 1'b1;
            end
        end
    end

    // peak current interval per high side
    logic [CNT_W-1:0] peak_cnt_ff [swfs_pkg::NUM_HS];
    logic [3:0] peak_ff;
    for (genvar h = 0; h < swfs_pkg::NUM_HS; h++) begin : g_peak
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                peak_cnt_ff[h] <= '0;
                peak_ff[h] <= 1'b0;
            end else if (!nxt_drive[h]) begin
                peak_cnt_ff[h] <= '0;
                peak_ff[h] <= 1'b0;
            end else if (!drive_ff[h]) begin
                // switch-on: bit 0 starts peak, bit 1 skips it
                peak_cnt_ff[h] <= CNT_W'(PEAK_CYC - 1);
                peak_ff[h] <= ~occfg_ff[h];
            end else if (peak_cnt_ff[h] != '0) begin
                peak_cnt_ff[h] <= peak_cnt_ff[h] - 1'b1;
            end else begin
                peak_ff[h] <= 1'b0;
            end
        end
    end

    // fault events and conditions still present
    assign ol_ev = {ol_fire, ol[3:0] & ol_en[3:0]};
    assign set_ev = ot_ev | ol_ev | {oc_fire, 4'h0}
                  | {12{ov}};
    assign hs_live = (ol[3:0] & ol_en[3:0] & ~cmd[3:0])
                   | (ot[3:0] & ot_hold_ff[3:0]);
    assign live = {ot[11:4] & ot_hold_ff[11:4], 4'h0}
                | {ol_arm, hs_live}
                | {oc_arm & oc_lock_ff, 4'h0}
                | {12{ov}};

    // status: event beats the chip-select clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_ff <= 12'h000;
        end else if (cs_rise) begin
            status_ff <= (status_ff & live) | set_ev;
        end else begin
            status_ff <= status_ff | set_ev;
        end
    end

    // low-side flag latch, released by a command toggle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ls_flag_ff <= 8'h00;
        end else begin
            ls_flag_ff <= (ls_flag_ff & ~ls_toggle)
                        | ot_ev[11:4] | ol_fire | oc_fire;
        end
    end

    // registered pin outputs
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fault_flag_n <= 1'b1;
        end else begin
            fault_flag_n <= ~(ov | (|hs_live) | (|ls_flag_ff));
        end
    end
    assign high_side_outputs = drive_ff[3:0];
    assign low_side_outputs = drive_ff[11:4];
    assign hs_peak_limit = peak_ff;

    // buffer ready keeps its drain honest; unused in steady state
    logic unused_ready;
    assign unused_ready = buf_in_ready;
endmodule
`default_nettype wire

/* verification/swfs_core_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module swfs_core_properties #(
    parameter int PEAK_CYC = 20
) (
    input wire logic clock, // system clock
    input wire logic rstn, // async reset
    input wire logic cs_n, // chip select
    input wire logic so, // serial out
    input wire logic so_oe_n, // serial out enable
    input wire logic ov_sense, // overvoltage
    input wire logic [11:0] ot_sense, // overtemp
    input wire logic [11:0] ol_sense, // open load
    input wire logic [7:0] oc_sense, // overcurrent
    input wire logic [3:0] high_side_outputs, // hs drive
    input wire logic [7:0] low_side_outputs, // ls drive
    input wire logic [3:0] hs_peak_limit, // peak limit
    input wire logic fault_flag_n // fault flag
);
    logic [3:0] quiet_ff;
    logic [31:0] peak_ff;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // cycles since any fault input was high; a flag drop needs a cause
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            quiet_ff <= 4'hf;
        end else if (ov_sense || |{ot_sense, ol_sense, oc_sense}) begin
            quiet_ff <= 4'h0;
        end else if (quiet_ff != 4'hf) begin
            quiet_ff <= quiet_ff + 4'h1;
        end
    end
    // length of the current peak interval on output 0
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            peak_ff <= '0;
        end else begin
            peak_ff <= hs_peak_limit[0] ? peak_ff + 1 : '0;
        end
    end
    a_release_so: assert property (
        cs_n [*6] |-> so_oe_n) else $error("serial out driven unselected");
    a_drive_so: assert property (
        !cs_n [*6] |-> !so_oe_n) else $error("serial out not driven");
    a_quiet_so: assert property (
        cs_n [*6] |-> $stable(so)) else $error("serial out moved unselected");
    a_ov_all_off: assert property (
        ov_sense [*5] |-> high_side_outputs == 4'h0 && low_side_outputs == 0)
        else $error("output on during overvoltage");
    a_ov_flag: assert property (
        ov_sense [*5] |-> !fault_flag_n) else $error("flag high in overvoltage");
    a_hs_ot_off: assert property (
        ot_sense[0] [*5] |-> !high_side_outputs[0]) else $error("hot hs on");
    a_ls_ot_off: assert property (
        ot_sense[4] [*5] |-> !low_side_outputs[0]) else $error("hot ls on");
    a_peak_bound: assert property (
        peak_ff <= PEAK_CYC + 2) else $error("peak limit held too long");
    a_flag_cause: assert property (
        $fell(fault_flag_n) |-> quiet_ff < 4'h8) else $error("flag no cause");
    c_ov: cover property (ov_sense ##5 !fault_flag_n);
    c_peak: cover property ($rose(hs_peak_limit[0]));
    c_ls_trip: cover property (oc_sense[0] ##1 $fell(low_side_outputs[0]));
endmodule
bind swfs_core swfs_core_properties #(.PEAK_CYC(PEAK_CYC)) u_props (
    .clock(clock), .rstn(rstn), .cs_n(cs_n), .so(so), .so_oe_n(so_oe_n),
    .ov_sense(ov_sense), .ot_sense(ot_sense), .ol_sense(ol_sense),
    .oc_sense(oc_sense), .high_side_outputs(high_side_outputs),
    .low_side_outputs(low_side_outputs), .hs_peak_limit(hs_peak_limit),
    .fault_flag_n(fault_flag_n));
`default_nettype wire

/* verification/swfs_host.sv */
`timescale 1ns/10ps
`default_nettype none
module swfs_host (
    input wire logic clock, // bench clock
    output var logic cs_n, // chip select
    output var logic sclk, // serial clock
    output var logic si, // serial data to device
    input wire logic so // serial data from device
);
    int half = 4; // clocks per serial clock half period
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    // one frame of n bits, msb first, reply taken on falling edges
    task automatic xfer(input logic [15:0] w, input int n,
            output logic [15:0] r);
        r = 16'h0000;
        @(posedge clock);
        #1;
        cs_n = 1'b0;
        repeat (8) @(posedge clock);
        for (int i = n - 1; i >= 0; i--) begin
            #1;
            sclk = 1'b1;
            si = w[i];
            repeat (half) @(posedge clock);
            #1;
            sclk = 1'b0;
            r = {r[14:0], so};
            repeat (half) @(posedge clock);
        end
        #1;
        cs_n = 1'b1;
        si = ~si; // released line does not keep its value
        repeat (10) @(posedge clock);
    endtask
endmodule
`default_nettype wire

/* verification/test_switch_fault_status_spi.sv */
`timescale 1ns/10ps
`default_nettype none
module test_switch_fault_status_spi;
    localparam int FILT = 8;
    localparam int PEAK = 20;
    logic clock, rstn, cs_n, sclk, si, so, so_oe_n, lowside_direct_in;
    logic ov_sense, fault_flag_n;
    logic [3:0] highside_direct_in, high_side_outputs, hs_peak_limit;
    logic [11:0] ot_sense, ol_sense;
    logic [7:0] oc_sense, low_side_outputs;
    logic [15:0] reply;
    int errors = 0;
    int comparisons = 0;
    swfs_core #(.FILTER_CYC(FILT), .PEAK_CYC(PEAK)) DUT (
        .clock(clock), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .si(si),
        .so(so), .so_oe_n(so_oe_n), .highside_direct_in(highside_direct_in),
        .lowside_direct_in(lowside_direct_in), .ov_sense(ov_sense),
        .ot_sense(ot_sense), .ol_sense(ol_sense), .oc_sense(oc_sense),
        .high_side_outputs(high_side_outputs),
        .low_side_outputs(low_side_outputs), .hs_peak_limit(hs_peak_limit),
        .fault_flag_n(fault_flag_n));
    swfs_host host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .si(si),
        .so(so));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] exp,
            input logic [15:0] seen);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] w);
        host.xfer(w, 16, reply);
        #1;
    endtask
    task automatic complete_run();
        $display("%0d comparisons, %0d errors", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // hs open load live from reset, ls detection off
    task automatic t_reset();
        ol_sense = 12'h011;
        step(6);
        check("flag", 16'h0000, 16'(fault_flag_n));
        wr(16'h3000);
        check("status", 16'h0001, reply);
        ol_sense = 12'h000;
        step(6);
        check("flag", 16'h0001, 16'(fault_flag_n));
        wr(16'h3000);
        check("status", 16'h0001, reply);
        wr(16'h3000);
        check("status", 16'h0000, reply);
        $display("reset test done");
    endtask
    task automatic t_drive();
        wr(16'h8a5c);
        check("ls drive", 16'h00a5, 16'(low_side_outputs));
        check("hs drive", 16'h000c, 16'(high_side_outputs));
        check("peak", 16'h000c, 16'(hs_peak_limit));
        step(PEAK + 5);
        check("peak", 16'h0000, 16'(hs_peak_limit));
        wr(16'h3000);
        check("status", 16'h8000, reply);
        $display("drive test done");
    endtask
    // short frame dropped, then a slow host
    task automatic t_discard();
        host.xfer(16'h0fff, 12, reply);
        #1;
        check("ls drive", 16'h00a5, 16'(low_side_outputs));
        host.half = 8;
        wr(16'h0003);
        host.half = 4;
        check("hs drive", 16'h0003, 16'(high_side_outputs));
        $display("discard test done");
    endtask
    task automatic t_overvoltage();
        wr(16'h0fff);
        ov_sense = 1'b1;
        step(6);
        check("drive", 16'h0000, {high_side_outputs, low_side_outputs});
        check("flag", 16'h0000, 16'(fault_flag_n));
        wr(16'h3000);
        check("status", 16'h0fff, reply);
        ov_sense = 1'b0;
        step(6);
        check("flag", 16'h0001, 16'(fault_flag_n));
        check("hs drive", 16'h000f, 16'(high_side_outputs));
        wr(16'h3000);
        check("status", 16'h0fff, reply);
        wr(16'h3000);
        check("status", 16'h0000, reply);
        $display("overvoltage test done");
    endtask
    task automatic t_overcurrent();
        int n;
        wr(16'h5012);
        wr(16'h0010);
        oc_sense = 8'h01;
        step(FILT - 2);
        oc_sense = 8'h00;
        step(6);
        check("ls drive", 16'h0001, 16'(low_side_outputs));
        oc_sense = 8'h01;
        for (n = 0; n < FILT + 10 && low_side_outputs[0] !== 1'b0; n++) begin
            step(1);
        end
        if (n == FILT + 10) begin
            errors++;
            complete_run();
        end
        oc_sense = 8'h00;
        step(6);
        check("flag", 16'h0000, 16'(fault_flag_n));
        check("ls drive", 16'h0000, 16'(low_side_outputs));
        wr(16'h3000);
        check("status", 16'h0010, reply);
        wr(16'h0000);
        wr(16'h0010);
        check("ls drive", 16'h0001, 16'(low_side_outputs));
        check("flag", 16'h0001, 16'(fault_flag_n));
        wr(16'h0030);
        oc_sense = 8'h02;
        step(3 * FILT);
        check("ls drive", 16'h0003, 16'(low_side_outputs));
        wr(16'h3000);
        check("status", 16'h0000, reply);
        oc_sense = 8'h00;
        $display("overcurrent test done");
    endtask
    task automatic t_overtemp();
        wr(16'h0003);
        check("peak", 16'h0001, 16'(hs_peak_limit));
        ot_sense = 12'h001;
        step(6);
        check("hs drive", 16'h0002, 16'(high_side_outputs));
        ot_sense = 12'h000;
        step(6);
        check("hs drive", 16'h0003, 16'(high_side_outputs));
        wr(16'h0010);
        ot_sense = 12'h010;
        step(6);
        ot_sense = 12'h000;
        step(6);
        check("ls drive", 16'h0000, 16'(low_side_outputs));
        check("flag", 16'h0000, 16'(fault_flag_n));
        wr(16'h0000);
        wr(16'h0010);
        check("ls drive", 16'h0001, 16'(low_side_outputs));
        $display("overtemperature test done");
    endtask
    initial begin
        repeat (50000) @(posedge clock);
        errors++;
        complete_run();
    end
    initial begin
        rstn = 1'b0;
        ov_sense = 1'b0;
        ot_sense = 12'h000;
        ol_sense = 12'h000;
        oc_sense = 8'h00;
        highside_direct_in = 4'h0;
        lowside_direct_in = 1'b0;
        step(2);
        rstn = 1'b1;
        step(4);
        t_reset();
        t_drive();
        t_discard();
        t_overvoltage();
        t_overcurrent();
        t_overtemp();
        complete_run();
    end
endmodule
`default_nettype wire
